// ==== rtl/tcm_pkg.sv ====
// shared constants for the dual timer/counter block
// assumes a single core clock; addresses are special-function-register addresses
package tcm_pkg;

  // -----------------------------------------------------------------
  // register addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_LOW0 = 8'h8a;
  localparam logic [7:0] ADDR_LOW1 = 8'h8b;
  localparam logic [7:0] ADDR_HIGH0 = 8'h8c;
  localparam logic [7:0] ADDR_HIGH1 = 8'h8d;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // -----------------------------------------------------------------
  // timer_mode_select fields
  // -----------------------------------------------------------------
  localparam int GATE1_BIT = 7;
  localparam int CSEL1_BIT = 6;
  localparam int MODE1_LSB = 4;
  localparam int GATE0_BIT = 3;
  localparam int CSEL0_BIT = 2;
  localparam int MODE0_LSB = 0;

  // -----------------------------------------------------------------
  // timer_control fields
  // -----------------------------------------------------------------
  localparam int FLAG1_BIT = 7;
  localparam int RUN1_BIT = 6;
  localparam int FLAG0_BIT = 5;
  localparam int RUN0_BIT = 4;

  // -----------------------------------------------------------------
  // machine cycle timing in core clock periods, and the prescaler top count
  // -----------------------------------------------------------------
  localparam logic [3:0] CYCLE_CLKS = 4'hc;
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;
  localparam logic [3:0] UPDATE_PHASE = 4'h4;
  localparam logic [4:0] PRESCALE_TOP = 5'h1f;

  // -----------------------------------------------------------------
  // operating modes
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_13 = 2'b00,
    MODE_16 = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } tcm_mode_type;

endpackage : tcm_pkg

// ==== rtl/tcm_phase_if.sv ====
// strobes and pin events passed between the timer modules
// assumes all parties run on the same core clock
`timescale 1ns/100ps
`default_nettype none
interface tcm_phase_if;
  logic sample_stb;
  logic update_stb;
  logic [1:0] cnt_tick;
  logic [1:0] gate_lvl;

  modport phase (output sample_stb, output update_stb);
  modport pins (input sample_stb, input update_stb, output cnt_tick, output gate_lvl);
  modport core (input update_stb, input cnt_tick, input gate_lvl);
endinterface : tcm_phase_if
`default_nettype wire

// ==== rtl/tcm_phase_gen.sv ====
// machine cycle phase counter, twelve core clocks per cycle
// assumes ref_clk is the core clock and rst_n an async low reset
`timescale 1ns/100ps
`default_nettype none
module tcm_phase_gen
  import tcm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // phase strobes
  tcm_phase_if.phase ph
);

  logic [3:0] phase;
  logic [3:0] next_phase;

  // wrap after the last core clock of a machine cycle
  always_comb begin
    next_phase = (phase == CYCLE_CLKS - 4'h1) ? 4'h0 : phase + 4'h1; // [R1]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 4'h0;
    end else begin
      phase <= next_phase;
    end
  end

  // one-clock strobes at fixed phases
  assign ph.sample_stb = (phase == SAMPLE_PHASE); // [R3]
  assign ph.update_stb = (phase == UPDATE_PHASE); // [R5]

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_cycle_period: assert property (ph.update_stb |-> ##12 ph.update_stb) // [R1]
    else $error("update strobe not every twelve clocks");
  a_update_gap: assert property (ph.update_stb |=> !ph.update_stb [*8]) // [R1]
    else $error("update strobe repeats too soon");
  a_sample_to_update: assert property (ph.sample_stb |-> ##7 ph.update_stb) // [R3]
    else $error("sample phase misplaced against update phase");

endmodule : tcm_phase_gen
`default_nettype wire

// ==== rtl/tcm_pin_sampler.sv ====
// synchronises count and gate pins, detects falling count edges
// assumes pins are asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module tcm_pin_sampler (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pins: count zero, count one, gate zero, gate one
  input wire logic [3:0] pins_raw,
  // strobes and events
  tcm_phase_if.pins ph
);

  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [1:0] smp;
  logic [1:0] pend;
  logic [1:0] next_smp;
  logic [1:0] next_pend;

  // sample once per cycle, flag high-then-low until the next update
  always_comb begin
    next_smp = ph.sample_stb ? sync_b[1:0] : smp; // [R3]
    next_pend = ph.update_stb ? 2'b00 : pend;
    if (ph.sample_stb) begin
      next_pend = pend | (smp & ~sync_b[1:0]); // [R4]
    end
  end

  // two-stage synchroniser, then sample and pending state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      smp <= 2'b00;
      pend <= 2'b00;
    end else begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
      smp <= next_smp;
      pend <= next_pend;
    end
  end

  assign ph.cnt_tick = pend & {2{ph.update_stb}}; // [R5]
  assign ph.gate_lvl = sync_b[3:2];

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_edge_to_tick: assert property (ph.sample_stb && smp[0] && !sync_b[0] |-> ##7 ph.cnt_tick[0]) // [R5]
    else $error("falling edge not counted at update phase");
  a_tick_needs_edge: assert property (ph.cnt_tick[1] |-> $past(pend[1])) // [R4]
    else $error("count tick without detected edge");
  c_edge_seen: cover property (ph.cnt_tick[0]);

endmodule : tcm_pin_sampler
`default_nettype wire

// ==== rtl/tcm_timer_top.sv ====
// two timer/counters with mode and control registers on the sfr port
// assumes synchronous sfr strobes on ref_clk and asynchronous pins
//
// Function
// R1: timer function counts once per twelve clocks
// R2: each timer has high and low bytes
// R3: count pin sampled once per machine cycle
// R4: count on high sample then low sample
// R5: new count appears at update phase next
// R6: source holds each level one machine cycle
// R7: gate bit requires gate pin high
// R8: select bit chooses pin edges or cycles
// R9: mode fields at bits 5:4 and 1:0
// R10: mode 00 high byte with 5-bit prescaler
// R11: mode 01 cascades bytes to sixteen bits
// R12: mode 10 reloads low from high
// R13: mode 11 stops timer one
// R14: mode 11 splits timer zero bytes
// R15: mode register resets zero, byte access
// R16: control register resets zero, bit access
// R17: flags set on overflow, cleared on vector
// R18: run bits turn timers on and off
// R19: 13-bit count uses low five bits
// R20: all state on core clock and reset
`timescale 1ns/100ps
`default_nettype none
module tcm_timer_top
  import tcm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // external pins
  input wire logic count_input_zero,
  input wire logic count_input_one,
  input wire logic gate_pin_zero,
  input wire logic gate_pin_one,
  // sfr port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_idx,
  input wire logic sfr_bit_val,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // interrupt vector acknowledges
  input wire logic vec_ack_zero,
  input wire logic vec_ack_one,
  // flag outputs
  output logic overflow_flag_zero,
  output logic overflow_flag_one
);

  // -----------------------------------------------------------------
  // shared strobes
  // -----------------------------------------------------------------
  tcm_phase_if ph ();

  tcm_phase_gen u_phase (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ph(ph.phase)
  );

  tcm_pin_sampler u_pins (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pins_raw({gate_pin_one, gate_pin_zero, count_input_one, count_input_zero}),
    .ph(ph.pins)
  );

  // -----------------------------------------------------------------
  // one count step: {overflow, high byte, low byte}
  // -----------------------------------------------------------------
  function automatic logic [16:0] tcm_step(
    input tcm_mode_type m,
    input logic [7:0] hi,
    input logic [7:0] lo,
    input logic inc
  );
    logic [8:0] s;
    logic [16:0] w;
    s = {1'b0, lo} + 9'h001;
    w = {1'b0, hi, lo} + 17'h0_0001;
    tcm_step = {1'b0, hi, lo};
    if (inc) begin
      unique case (m)
        MODE_13: begin
          if (lo[4:0] == PRESCALE_TOP) begin
            s = {1'b0, hi} + 9'h001; // [R10]
            tcm_step = {s[8], s[7:0], lo[7:5], 5'h00}; // [R19]
          end else begin
            tcm_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01}; // [R19]
          end
        end
        MODE_16: tcm_step = w; // [R11]
        MODE_RELOAD: tcm_step = {s[8], hi, s[8] ? hi : s[7:0]}; // [R12]
        MODE_SPLIT: tcm_step = {s[8], hi, s[7:0]}; // [R14]
      endcase
    end
  endfunction : tcm_step

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [7:0] mode_sel;
  logic [7:0] ctl;
  logic [7:0] low0;
  logic [7:0] high0;
  logic [7:0] low1;
  logic [7:0] high1;
  logic [7:0] next_mode_sel;
  logic [7:0] next_ctl;
  logic [7:0] next_low0;
  logic [7:0] next_high0;
  logic [7:0] next_low1;
  logic [7:0] next_high1;
  logic [7:0] next_rdata;

  // -----------------------------------------------------------------
  // count enables
  // -----------------------------------------------------------------
  tcm_mode_type mode0;
  tcm_mode_type mode1;
  logic en0;
  logic en1;
  logic inc0;
  logic inc1;
  logic inc_h0;
  logic split0;

  assign mode0 = tcm_mode_type'(mode_sel[MODE0_LSB +: 2]); // [R9]
  assign mode1 = tcm_mode_type'(mode_sel[MODE1_LSB +: 2]); // [R9]
  assign split0 = (mode0 == MODE_SPLIT);

  // run bit, optionally qualified by the gate pin
  assign en0 = ctl[RUN0_BIT] & (~mode_sel[GATE0_BIT] | ph.gate_lvl[0]); // [R7] [R18]
  assign en1 = ctl[RUN1_BIT] & (~mode_sel[GATE1_BIT] | ph.gate_lvl[1]); // [R7] [R18]

  // counter select: pin edge tick or every machine cycle
  assign inc0 = ph.update_stb & en0 & (mode_sel[CSEL0_BIT] ? ph.cnt_tick[0] : 1'b1); // [R1] [R8]
  assign inc1 = ph.update_stb & en1 & (mode_sel[CSEL1_BIT] ? ph.cnt_tick[1] : 1'b1)
    & (mode1 != MODE_SPLIT); // [R13]

  // split high byte counts cycles under run_one, no gate
  assign inc_h0 = ph.update_stb & split0 & ctl[RUN1_BIT]; // [R14]

  // -----------------------------------------------------------------
  // next-state computation
  // -----------------------------------------------------------------
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0] hi_sum;
  logic set_f0;
  logic set_f1;
  logic wr_low0;
  logic wr_high0;
  logic wr_low1;
  logic wr_high1;

  assign wr_low0 = sfr_wr && (sfr_addr == ADDR_LOW0);
  assign wr_high0 = sfr_wr && (sfr_addr == ADDR_HIGH0);
  assign wr_low1 = sfr_wr && (sfr_addr == ADDR_LOW1);
  assign wr_high1 = sfr_wr && (sfr_addr == ADDR_HIGH1);

  // counting, software writes, flag updates
  always_comb begin
    step0 = tcm_step(mode0, high0, low0, inc0); // [R2]
    step1 = tcm_step(mode1, high1, low1, inc1); // [R2]
    hi_sum = {1'b0, high0} + 9'h001;
    next_low0 = wr_low0 ? sfr_wdata : step0[7:0];
    next_high0 = step0[15:8];
    if (inc_h0) begin
      next_high0 = hi_sum[7:0]; // [R14]
    end
    if (wr_high0) begin
      next_high0 = sfr_wdata;
    end
    next_low1 = wr_low1 ? sfr_wdata : step1[7:0];
    next_high1 = wr_high1 ? sfr_wdata : step1[15:8];
    // split mode: high byte of timer zero owns flag one
    set_f0 = step0[16];
    set_f1 = split0 ? (inc_h0 & hi_sum[8]) : step1[16]; // [R14] [R17]
    next_mode_sel = (sfr_wr && sfr_addr == ADDR_MODE) ? sfr_wdata : mode_sel; // [R15]
    next_ctl = ctl;
    if (sfr_wr && sfr_addr == ADDR_CONTROL) begin
      next_ctl = sfr_wdata;
    end
    if (sfr_bit_wr && sfr_addr == ADDR_CONTROL) begin
      next_ctl[sfr_bit_idx] = sfr_bit_val; // [R16]
    end
    if (vec_ack_zero) begin
      next_ctl[FLAG0_BIT] = 1'b0; // [R17]
    end
    if (vec_ack_one) begin
      next_ctl[FLAG1_BIT] = 1'b0; // [R17]
    end
    // hardware set wins over any clear in the same cycle
    if (set_f0) begin
      next_ctl[FLAG0_BIT] = 1'b1; // [R17]
    end
    if (set_f1) begin
      next_ctl[FLAG1_BIT] = 1'b1; // [R17]
    end
  end

  // read data mux, unmapped addresses read zero
  always_comb begin
    next_rdata = sfr_rdata;
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_CONTROL: next_rdata = ctl;
        ADDR_MODE: next_rdata = mode_sel;
        ADDR_LOW0: next_rdata = low0;
        ADDR_LOW1: next_rdata = low1;
        ADDR_HIGH0: next_rdata = high0;
        ADDR_HIGH1: next_rdata = high1;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // state registers
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_sel <= MODE_RESET; // [R15] [R20]
      ctl <= CONTROL_RESET; // [R16] [R20]
      low0 <= COUNT_RESET;
      high0 <= COUNT_RESET;
      low1 <= COUNT_RESET;
      high1 <= COUNT_RESET;
      sfr_rdata <= 8'h00;
    end else begin
      mode_sel <= next_mode_sel;
      ctl <= next_ctl;
      low0 <= next_low0;
      high0 <= next_high0;
      low1 <= next_low1;
      high1 <= next_high1;
      sfr_rdata <= next_rdata;
    end
  end

  assign overflow_flag_zero = ctl[FLAG0_BIT];
  assign overflow_flag_one = ctl[FLAG1_BIT];

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  logic no_wr0;
  logic no_wr1;
  logic no_ctl;

  assign no_wr0 = !wr_low0 && !wr_high0;
  assign no_wr1 = !wr_low1 && !wr_high1;
  assign no_ctl = !(sfr_addr == ADDR_CONTROL && (sfr_wr || sfr_bit_wr));

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_cycle_count: assert property (ph.update_stb && mode1 == MODE_16 && ctl[RUN1_BIT]
    && !mode_sel[GATE1_BIT] && !mode_sel[CSEL1_BIT] && no_wr1
    |=> {high1, low1} == $past({high1, low1}) + 16'h0001) // [R1] [R11]
    else $error("sixteen-bit timer did not step once");
  a_run_off_hold: assert property (!ctl[RUN0_BIT] && !wr_low0 |=> $stable(low0)) // [R18]
    else $error("timer zero low byte moved while stopped");
  a_gate_block: assert property (mode_sel[GATE1_BIT] && !ph.gate_lvl[1] && no_wr1
    |=> $stable({high1, low1})) // [R7]
    else $error("timer one counted with gate pin low");
  a_counter_hold: assert property (mode_sel[CSEL0_BIT] && !ph.cnt_tick[0] && !split0 && no_wr0
    |=> $stable({high0, low0})) // [R8]
    else $error("counter moved without pin edge");
  a_reload_value: assert property (mode0 == MODE_RELOAD && inc0 && low0 == 8'hff && no_wr0
    |=> low0 == $past(high0) && ctl[FLAG0_BIT]) // [R12]
    else $error("auto reload or flag wrong");
  a_stop_hold: assert property (mode1 == MODE_SPLIT && no_wr1 |=> $stable({high1, low1})) // [R13]
    else $error("timer one moved in stopped mode");
  a_prescale_wrap: assert property (mode0 == MODE_13 && inc0 && low0[4:0] == 5'h1f && no_wr0
    |=> low0[4:0] == 5'h00 && high0 == $past(high0) + 8'h01) // [R10] [R19]
    else $error("prescaler carry wrong");
  a_split_high: assert property (split0 && ctl[RUN1_BIT] && ph.update_stb && !wr_high0
    |=> high0 == $past(high0) + 8'h01) // [R14]
    else $error("split high byte did not count");
  a_flag_wins: assert property (set_f1 && no_ctl |=> ctl[FLAG1_BIT]) // [R17]
    else $error("overflow flag one lost");
  a_ack_clear: assert property (vec_ack_zero && !set_f0 && no_ctl |=> !ctl[FLAG0_BIT]) // [R17]
    else $error("flag zero not cleared on vector");

  c_reload_ovf: cover property (mode0 == MODE_RELOAD && set_f0);
  c_split_ovf: cover property (split0 && set_f1);
  c_gated_count: cover property (mode_sel[GATE0_BIT] && inc0);

endmodule : tcm_timer_top
`default_nettype wire

// ==== testbench/tcm_pin_model.sv ====
// model of the external drivers on the count and gate pins
// assumes ref_clk is the core clock; the bench requests levels
`timescale 1ns/100ps
`default_nettype none
module tcm_pin_model #(
  parameter int HOLD = 24
) (
  // clock
  input wire logic ref_clk,
  // requested levels: count zero, count one, gate zero, gate one
  input wire logic [3:0] level_req,
  // pin levels seen by the block
  output logic [3:0] pins
);
  int held [4];

  // idle: count pins high, gate pins low
  initial begin
    pins = 4'h3;
  end

  // a level stands at least HOLD clocks before it may change
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (held[i] < HOLD) begin
        held[i]++;
      end else if (level_req[i] !== pins[i]) begin
        pins[i] <= #3 level_req[i];
        held[i] = 0;
      end
    end
  end
endmodule : tcm_pin_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the dual timer/counter block
// assumes the pin model drives the pins and the bench the sfr port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tcm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] level_req = 4'h3;
  logic [3:0] pins;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_bit_wr = 1'b0;
  logic [2:0] sfr_bit_idx = 3'h0;
  logic sfr_bit_val = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic vec_ack_zero = 1'b0;
  logic vec_ack_one = 1'b0;
  logic overflow_flag_zero;
  logic overflow_flag_one;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int k;
  logic [7:0] d;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [15:0] s;

  // -----------------------------------------------------------------
  // clock, pins, block
  // -----------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;

  tcm_pin_model u_pins (.ref_clk(ref_clk), .level_req(level_req), .pins(pins));

  tcm_timer_top u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .count_input_zero(pins[0]), .count_input_one(pins[1]),
    .gate_pin_zero(pins[2]), .gate_pin_one(pins[3]),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .vec_ack_zero(vec_ack_zero), .vec_ack_one(vec_ack_one),
    .overflow_flag_zero(overflow_flag_zero), .overflow_flag_one(overflow_flag_one)
  );

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // -----------------------------------------------------------------
  // tasks and expectation helpers
  // -----------------------------------------------------------------
  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  // kind 0 byte write, 1 bit write (v[7] value, v[2:0] index), 2 read
  task automatic acc(input int kind, input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_bit_idx = v[2:0];
    sfr_bit_val = v[7];
    sfr_wr = (kind == 0);
    sfr_bit_wr = (kind == 1);
    sfr_rd = (kind == 2);
    idle(1);
    sfr_wr = 1'b0;
    sfr_bit_wr = 1'b0;
    sfr_rd = 1'b0;
    idle(1);
    d = sfr_rdata;
  endtask : acc

  task automatic rdb(input string what, input logic [7:0] a, input logic [7:0] exp);
    acc(2, a, 8'h00);
    chk(what, d, exp);
  endtask : rdb

  function automatic logic [7:0] run_bit(input int t, input logic v);
    return {v, 4'h0, 3'(t ? RUN1_BIT : RUN0_BIT)};
  endfunction : run_bit

  // run bit high for exactly k machine cycles
  task automatic run_win(input int t, input int k);
    acc(1, ADDR_CONTROL, run_bit(t, 1'b1));
    idle(12 * k - 2);
    acc(1, ADDR_CONTROL, run_bit(t, 1'b0));
  endtask : run_win

  task automatic ack(input int t);
    if (t != 0) vec_ack_one = 1'b1;
    else vec_ack_zero = 1'b1;
    idle(1);
    vec_ack_one = 1'b0;
    vec_ack_zero = 1'b0;
    idle(1);
  endtask : ack

  function automatic logic [7:0] reload_exp(input logic [7:0] tl, input logic [7:0] th, int k);
    repeat (k) tl = (tl == 8'hff) ? th : tl + 8'h01;
    return tl;
  endfunction : reload_exp

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(83));
    idle(2);
    rst_n = 1'b1;
    rdb("control reset", ADDR_CONTROL, CONTROL_RESET);
    rdb("mode reset", ADDR_MODE, MODE_RESET);
    rdb("unmapped", 8'h90, 8'h00);
    lo = $urandom;
    acc(0, ADDR_MODE, lo);
    acc(1, ADDR_MODE, {~lo[0], 7'h00});
    rdb("mode byte only", ADDR_MODE, lo);
    acc(1, ADDR_CONTROL, 8'h80);
    rdb("control bit set", ADDR_CONTROL, 8'h01);
    acc(1, ADDR_CONTROL, 8'h00);
    // sixteen-bit timer, then overflow and vector clear, both timers
    for (int t = 0; t < 2; t++) begin
      lo = $urandom;
      hi = $urandom;
      k = 1 + $urandom % 4;
      acc(0, ADDR_MODE, t ? 8'h10 : 8'h01);
      acc(0, 8'(ADDR_LOW0 + t), lo);
      acc(0, 8'(ADDR_HIGH0 + t), hi);
      run_win(t, k);
      s = {hi, lo} + 16'(k);
      rdb("low mode1", 8'(ADDR_LOW0 + t), s[7:0]);
      rdb("high mode1", 8'(ADDR_HIGH0 + t), s[15:8]);
      acc(0, 8'(ADDR_LOW0 + t), 8'hff);
      acc(0, 8'(ADDR_HIGH0 + t), 8'hff);
      run_win(t, 1);
      chk("flag set", t ? overflow_flag_one : overflow_flag_zero, 8'h01);
      rdb("flag in control", ADDR_CONTROL, t ? 8'h80 : 8'h20);
      ack(t);
      chk("flag clear", t ? overflow_flag_one : overflow_flag_zero, 8'h00);
    end
    // thirteen-bit mode with low five bits at top
    hi = $urandom;
    lo = $urandom | 8'h1f;
    k = 1 + $urandom % 4;
    acc(0, ADDR_MODE, 8'h00);
    acc(0, ADDR_LOW0, lo);
    acc(0, ADDR_HIGH0, hi);
    run_win(0, k);
    s = {3'h0, hi, lo[4:0]} + 16'(k);
    acc(2, ADDR_LOW0, 8'h00);
    chk("low mode0", d & 8'h1f, s[4:0]);
    rdb("high mode0", ADDR_HIGH0, s[12:5]);
    // auto reload across overflow
    hi = $urandom;
    acc(0, ADDR_MODE, 8'h02);
    acc(0, ADDR_LOW0, 8'hfe);
    acc(0, ADDR_HIGH0, hi);
    run_win(0, 3);
    rdb("low reload", ADDR_LOW0, reload_exp(8'hfe, hi, 3));
    rdb("high reload", ADDR_HIGH0, hi);
    ack(0);
    // split timer zero, timer one stopped
    lo = $urandom;
    hi = $urandom;
    acc(0, ADDR_MODE, 8'h33);
    acc(0, ADDR_LOW0, lo);
    acc(0, ADDR_HIGH0, 8'hfe);
    acc(0, ADDR_LOW1, hi);
    run_win(1, 3);
    rdb("high zero split", ADDR_HIGH0, 8'h01);
    rdb("low zero split", ADDR_LOW0, lo);
    rdb("low one stopped", ADDR_LOW1, hi);
    chk("split flag one", overflow_flag_one, 8'h01);
    ack(1);
    // gating by the gate pin, both timers
    for (int t = 0; t < 2; t++) begin
      acc(0, ADDR_MODE, t ? 8'h90 : 8'h09);
      acc(0, 8'(ADDR_LOW0 + t), 8'h00);
      run_win(t, 2);
      rdb("gate low", 8'(ADDR_LOW0 + t), 8'h00);
      level_req[2 + t] = 1'b1;
      idle(40);
      run_win(t, 2);
      rdb("gate high", 8'(ADDR_LOW0 + t), 8'h02);
      level_req[2 + t] = 1'b0;
    end
    // falling pin edges counted in counter function
    for (int t = 0; t < 2; t++) begin
      k = 1 + $urandom % 3;
      acc(0, ADDR_MODE, t ? 8'h50 : 8'h05);
      acc(0, 8'(ADDR_LOW0 + t), 8'h00);
      acc(1, ADDR_CONTROL, run_bit(t, 1'b1));
      repeat (k) begin
        level_req[t] = 1'b0;
        idle(40);
        level_req[t] = 1'b1;
        idle(40);
      end
      acc(1, ADDR_CONTROL, run_bit(t, 1'b0));
      rdb("edge count", 8'(ADDR_LOW0 + t), 8'(k));
    end
    // reset in mid-run clears state
    acc(1, ADDR_CONTROL, run_bit(0, 1'b1));
    rst_n = 1'b0;
    idle(1);
    rst_n = 1'b1;
    rdb("mode after reset", ADDR_MODE, 8'h00);
    rdb("control after reset", ADDR_CONTROL, 8'h00);
    rdb("low one after reset", ADDR_LOW1, 8'h00);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
